// ---- hdl/liucd_top.sv ----
// one line interface channel: pattern test, loopbacks, all-ones and attenuator routing
// How it works
// RULE1: path select bit 0 puts attenuator in receive path, 1 in transmit path.
// RULE2: attenuator config bits zero and one together choose enable and depth.
// RULE3: both bits clear gives depth sixteen; bit zero set disables the attenuator.
// RULE4: attenuator reset bit set flushes buffer and pointers; software clears it.
// RULE5: pattern test works only under host register control, never pin strapping.
// RULE6: pattern test sends 2^23-1 sequence at E3, 2^15-1 at other rates.
// RULE7: enabling the pattern test also enables the receive checker.
// RULE8: checker lock drives the low-rail/violation output low.
// RULE9: out of sync sets sync-lost status and holds violation output high.
// RULE10: writing one to inject bit inserts exactly one transmitted bit error.
// RULE11: each detected bit error pulses violation output for one receive clock.
// RULE12: software writes inject bit back to zero before each further injection.
// RULE13: pattern test forces single-rail terminal operation.
// RULE14: loop selects come from pins in pin mode, control register in host mode.
// RULE15: analog loop feeds line transmit into receiver, shown on receive outputs.
// RULE16: analog loop keeps driving the line and ignores the line receive inputs.
// RULE17: analog loop passes through the attenuator in its assigned path.
// RULE18: digital loop returns terminal clock and data on receive outputs.
// RULE19: remote loop sends receive data back out on recovered clock timing.
// RULE20: remote loop with attenuator in transmit passes through it there.
// RULE21: remote loop ignores terminal transmit clock and data inputs.
// RULE22: all-ones pin or bit sends alternating-mark all-ones at terminal clock.
// RULE23: all-ones is suppressed in analog and remote loop, kept in digital.
// RULE24: mapping of loop select pair to loop modes is a parameter.
//
// Local design decisions: the register addresses and the strobed register port.
`timescale 1ns/1ps
`include "liucd_defines.svh"
module liucd_top #(
    parameter logic [7:0] LOOP_MAP = `LIUCD_LOOP_MAP_DEF
) (
    input wire logic CLK,
    input wire logic RSTN,
    input wire logic [7:0] ADDR,
    input wire logic [7:0] WDATA,
    input wire logic WR,
    input wire logic RD,
    output logic [7:0] RDATA,
    input wire logic HOST_MODE,
    input wire logic REMOTE_LOOP_SELECT,
    input wire logic LOCAL_LOOP_SELECT,
    input wire logic SEND_ALL_ONES,
    input wire logic TERMINAL_TX_CLOCK,
    input wire logic TX_POSITIVE_DATA,
    input wire logic TX_NEGATIVE_DATA,
    input wire logic LINE_RX_CLOCK,
    input wire logic LINE_RX_POSITIVE,
    input wire logic LINE_RX_NEGATIVE,
    output logic RECEIVE_CLOCK_OUT,
    output logic RX_POSITIVE_DATA,
    output logic RX_LOW_RAIL_VIOLATION_OUT,
    output logic LINE_TX_POSITIVE,
    output logic LINE_TX_NEGATIVE,
    output logic PATTERN_SYNC_LOST
);
    // every pin input outside the register port crosses two flops before anything looks at it
    logic [9:0] sync1_r;
    logic [9:0] sync2_r;
    logic tclk_d_r;
    logic rclk_d_r;
    wire [9:0] pins_in = {LINE_RX_NEGATIVE, LINE_RX_POSITIVE, LINE_RX_CLOCK,
                          TX_NEGATIVE_DATA, TX_POSITIVE_DATA, TERMINAL_TX_CLOCK,
                          SEND_ALL_ONES, LOCAL_LOOP_SELECT, REMOTE_LOOP_SELECT, HOST_MODE};
    wire host_s = sync2_r[0];
    wire tclk_s = sync2_r[4];
    wire tpos_s = sync2_r[5];
    wire tneg_s = sync2_r[6];
    wire rclk_s = sync2_r[7];
    wire lrxp_s = sync2_r[8];
    wire lrxn_s = sync2_r[9];

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            sync1_r <= 10'h0;
            sync2_r <= 10'h0;
            tclk_d_r <= 1'b0;
            rclk_d_r <= 1'b0;
        end else begin
            sync1_r <= pins_in;
            sync2_r <= sync1_r;
            tclk_d_r <= tclk_s;
            rclk_d_r <= rclk_s;
        end
    end

    wire tx_ev = tclk_s & ~tclk_d_r;
    wire rx_ev = rclk_s & ~rclk_d_r;

    // register file
    logic [7:0] ctrl_r;
    logic [7:0] ja_r;
    logic inj_d_r;
    logic chk_locked;
    logic chk_err;
    wire wr_ctrl = WR && ADDR == `LIUCD_ADDR_CHAN_CTRL;
    wire wr_ja = WR && ADDR == `LIUCD_ADDR_JA_CTRL;
    wire [7:0] stat_val = {6'h0, chk_locked, PATTERN_SYNC_LOST};
    wire [7:0] rd_mux = (ADDR == `LIUCD_ADDR_CHAN_CTRL) ? ctrl_r :
                        (ADDR == `LIUCD_ADDR_JA_CTRL) ? ja_r :
                        (ADDR == `LIUCD_ADDR_STATUS) ? stat_val : 8'h00;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ctrl_r <= `LIUCD_RESET_VAL;
            ja_r <= `LIUCD_RESET_VAL;
            RDATA <= 8'h00;
        end else begin
            if (wr_ctrl) begin
                ctrl_r <= WDATA & `LIUCD_CTRL_MASK;
            end
            if (wr_ja) begin
                ja_r <= WDATA & `LIUCD_JA_MASK;
            end
            RDATA <= RD ? rd_mux : 8'h00;
        end
    end

    // mode decode
    wire rlb_sel = host_s ? ctrl_r[`LIUCD_CTRL_RLB] : sync2_r[1]; // see RULE14
    wire llb_sel = host_s ? ctrl_r[`LIUCD_CTRL_LLB] : sync2_r[2]; // see RULE14
    wire taos_sel = host_s ? ctrl_r[`LIUCD_CTRL_TAOS] : sync2_r[3]; // see RULE22
    wire [2:0] map_pos = {rlb_sel, llb_sel, 1'b0};
    wire [1:0] map_code = LOOP_MAP[map_pos +: 2]; // see RULE24
    liucd_pkg::liucd_loop_e loop_mode;
    assign loop_mode = liucd_pkg::liucd_loop_e'(map_code);
    wire is_analog = loop_mode == liucd_pkg::LIUCD_LOOP_ANALOG;
    wire is_digital = loop_mode == liucd_pkg::LIUCD_LOOP_DIGITAL;
    wire is_remote = loop_mode == liucd_pkg::LIUCD_LOOP_REMOTE;
    // checker runs on this enable; the generator also needs all-ones off and no remote loop
    wire prbs_on = host_s & ctrl_r[`LIUCD_CTRL_PTE]; // see RULE5 see RULE7
    wire long_mode = ctrl_r[`LIUCD_CTRL_E3]; // see RULE6
    wire all_ones_on = taos_sel & ~is_analog & ~is_remote; // see RULE23

    // attenuator configuration
    wire ja_en = ~ja_r[`LIUCD_JA_B0]; // see RULE2 see RULE3
    wire ja_in_tx = ja_r[`LIUCD_JA_TX]; // see RULE1
    wire ja_flush = ja_r[`LIUCD_JA_RST]; // see RULE4
    wire [4:0] ja_depth = ja_r[`LIUCD_JA_B1] ? `LIUCD_JA_DEPTH_LONG
                                             : `LIUCD_JA_DEPTH_SHORT; // see RULE3
    wire ja_tx_on = ja_en & ja_in_tx;
    wire ja_rx_on = ja_en & ~ja_in_tx;

    // timing: remote loop transmits on recovered clock, analog receives on transmit timing
    wire tx_time_ev = is_remote ? rx_ev : tx_ev; // see RULE19 see RULE20 see RULE21
    wire rx_time_ev = is_analog ? tx_time_ev : rx_ev; // see RULE15

    // receive side before and after the attenuator; analog ignores the line pins
    wire rx_raw_p = is_analog ? LINE_TX_POSITIVE : lrxp_s; // see RULE15 see RULE16
    wire rx_raw_n = is_analog ? LINE_TX_NEGATIVE : lrxn_s; // see RULE16
    liucd_pkg::liucd_rail_t ja_out;
    wire rx_post_p = ja_rx_on ? ja_out[1] : rx_raw_p; // see RULE17
    wire rx_post_n = ja_rx_on ? ja_out[0] : rx_raw_n;

    // pattern generator with one-shot error injection
    logic [22:0] gen_r;
    logic inj_pend_r;
    logic ami_r;
    wire gen_fb = long_mode ? (gen_r[22] ^ gen_r[17]) : (gen_r[14] ^ gen_r[13]); // see RULE6
    // a new rise needs the bit written back to zero first
    wire inj_rise = ctrl_r[`LIUCD_CTRL_INJ] & ~inj_d_r; // see RULE12
    wire prbs_sel = prbs_on & ~all_ones_on & ~is_remote;
    wire inj_take = prbs_sel & tx_time_ev & inj_pend_r;
    wire gen_bit = gen_fb ^ inj_pend_r; // see RULE10

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            gen_r <= `LIUCD_PRBS_SEED;
            inj_pend_r <= 1'b0;
            inj_d_r <= 1'b0;
            ami_r <= 1'b0;
        end else begin
            inj_d_r <= ctrl_r[`LIUCD_CTRL_INJ];
            // a rise in the cycle of consumption is kept, set wins
            inj_pend_r <= (prbs_on & inj_rise) | (inj_pend_r & prbs_on & ~inj_take); // see RULE10
            if (prbs_sel && tx_time_ev) begin
                gen_r <= {gen_r[21:0], gen_fb};
            end
            if (all_ones_on && tx_time_ev) begin
                ami_r <= ~ami_r; // see RULE22
            end
        end
    end

    // transmit source before the attenuator
    logic tx_src_p;
    logic tx_src_n;
    always_comb begin
        if (is_remote) begin
            tx_src_p = rx_post_p; // see RULE19 see RULE21
            tx_src_n = rx_post_n;
        end else if (all_ones_on) begin
            tx_src_p = ami_r; // see RULE22
            tx_src_n = ~ami_r;
        end else if (prbs_sel) begin
            tx_src_p = gen_bit;
            tx_src_n = 1'b0; // see RULE13
        end else begin
            tx_src_p = tpos_s;
            tx_src_n = tneg_s;
        end
    end
    wire tx_post_p = ja_tx_on ? ja_out[1] : tx_src_p; // see RULE1 see RULE20
    wire tx_post_n = ja_tx_on ? ja_out[0] : tx_src_n;

    // attenuator: a fixed-lag buffer stepped by the timing of the path it sits in
    logic [4:0] ja_wptr_r;
    wire ja_ev = ja_en & (ja_in_tx ? tx_time_ev : rx_time_ev); // see RULE1
    wire [1:0] ja_din = ja_in_tx ? {tx_src_p, tx_src_n} : {rx_raw_p, rx_raw_n};
    wire [4:0] ja_raddr = ja_wptr_r - ja_depth;

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            ja_wptr_r <= 5'h0;
        end else if (ja_flush) begin
            ja_wptr_r <= 5'h0; // see RULE4
        end else if (ja_ev) begin
            ja_wptr_r <= ja_wptr_r + 5'h1;
        end
    end

    liucd_ja_mem u_ja_mem (
        .clk(CLK),
        .rstn(RSTN),
        .flush(ja_flush),
        .we(ja_ev & ~ja_flush),
        .waddr(ja_wptr_r),
        .wdata(ja_din),
        .raddr(ja_raddr),
        .rdata(ja_out)
    );

    // line transmit stays active in analog loop
    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            LINE_TX_POSITIVE <= 1'b0;
            LINE_TX_NEGATIVE <= 1'b0;
        end else if (tx_time_ev) begin
            LINE_TX_POSITIVE <= tx_post_p; // see RULE16
            LINE_TX_NEGATIVE <= tx_post_n;
        end
    end

    // receive outputs; digital loop hands terminal clock and data straight back
    wire rx_fin_ev = is_digital ? tx_ev : rx_time_ev;
    wire rx_fin_p = is_digital ? tpos_s : rx_post_p; // see RULE18
    wire rx_fin_n = is_digital ? tneg_s : rx_post_n;
    wire rclk_src = (is_digital | is_analog) ? tclk_s : rclk_s; // see RULE18
    logic rx_neg_r;

    liucd_prbs_chk u_chk (
        .clk(CLK),
        .rstn(RSTN),
        .enable(prbs_on), // see RULE7
        .long_mode(long_mode),
        .ev(rx_fin_ev),
        .din(rx_fin_p),
        .locked(chk_locked),
        .err_hold(chk_err)
    );

    always_ff @(posedge CLK or negedge RSTN) begin
        if (!RSTN) begin
            RECEIVE_CLOCK_OUT <= 1'b0;
            RX_POSITIVE_DATA <= 1'b0;
            rx_neg_r <= 1'b0;
            RX_LOW_RAIL_VIOLATION_OUT <= 1'b0;
            PATTERN_SYNC_LOST <= 1'b0;
        end else begin
            RECEIVE_CLOCK_OUT <= rclk_src;
            if (rx_fin_ev) begin
                RX_POSITIVE_DATA <= rx_fin_p;
                rx_neg_r <= rx_fin_n;
            end
            // the pin carries lock and error flags while the test runs
            RX_LOW_RAIL_VIOLATION_OUT <= prbs_on ? (~chk_locked | chk_err)
                                                 : (rx_fin_ev ? rx_fin_n : rx_neg_r); // see RULE8 see RULE9 see RULE11
            PATTERN_SYNC_LOST <= prbs_on & ~chk_locked; // see RULE9
        end
    end

    // checks
    default clocking cb @(posedge CLK); endclocking
    default disable iff (!RSTN);

    ja_tx_path_a: assert property ((ja_tx_on && tx_time_ev && !ja_flush)
        |=> LINE_TX_POSITIVE == $past(ja_out[1])) // see RULE1
        else $error("tx path does not carry attenuator output");

    ja_bypass_a: assert property ((!ja_en && tx_time_ev)
        |=> LINE_TX_POSITIVE == $past(tx_src_p) && LINE_TX_NEGATIVE == $past(tx_src_n)) // see RULE3
        else $error("disabled attenuator still in path");

    ja_flush_a: assert property ($rose(ja_flush) |=> ja_wptr_r == 5'h0 && ja_out == 2'h0) // see RULE4
        else $error("attenuator reset did not flush");

    prbs_host_a: assert property (!host_s |-> !prbs_on ##1 !chk_locked) // see RULE5
        else $error("pattern test active in pin mode");

    sync_lost_a: assert property ((prbs_on && !chk_locked) |=> RX_LOW_RAIL_VIOLATION_OUT
        && PATTERN_SYNC_LOST) // see RULE9
        else $error("sync loss not shown");

    sync_ok_a: assert property ((prbs_on && chk_locked && !chk_err)
        |=> !RX_LOW_RAIL_VIOLATION_OUT) // see RULE8
        else $error("lock not shown low");

    inject_once_a: assert property (inj_take |=> !inj_pend_r || $past(inj_rise)) // see RULE10
        else $error("injection not consumed once");

    single_rail_a: assert property ((prbs_sel && tx_time_ev && !ja_tx_on)
        |=> !LINE_TX_NEGATIVE) // see RULE13
        else $error("negative rail active in pattern test");

    remote_loop_a: assert property ((is_remote && rx_ev && !ja_tx_on)
        |=> LINE_TX_POSITIVE == $past(rx_post_p)) // see RULE21
        else $error("remote loop data not returned");

    digital_loop_a: assert property (is_digital ##1 is_digital
        |-> RECEIVE_CLOCK_OUT == $past(tclk_s)) // see RULE18
        else $error("digital loop clock not returned");

    ami_ones_a: assert property ((all_ones_on && tx_time_ev && !ja_tx_on)
        |=> LINE_TX_POSITIVE != LINE_TX_NEGATIVE) // see RULE22
        else $error("all-ones not alternate mark");

    aos_suppress_a: assert property ((is_analog || is_remote) |-> !all_ones_on) // see RULE23
        else $error("all-ones active in analog or remote loop");

    // analog loop: receive data passes the receive attenuator, receive clock comes from the transmit side
    analog_ja_rx_a: assert property ((is_analog && ja_rx_on && rx_time_ev) // see RULE17
        |=> RX_POSITIVE_DATA == $past(ja_out[1]))
        else $error("analog loop bypasses receive attenuator");

    analog_clk_a: assert property (is_analog ##1 is_analog // see RULE15
        |-> RECEIVE_CLOCK_OUT == $past(tclk_s))
        else $error("analog loop clock not from transmit side");

    lock_seen_c: cover property (prbs_on ##1 $rose(chk_locked));
    err_seen_c: cover property (chk_locked && $rose(chk_err));
    remote_c: cover property (is_remote && rx_ev);
    flush_c: cover property ($rose(ja_flush));
    analog_ja_c: cover property (is_analog && ja_rx_on && chk_err);
endmodule : liucd_top

// ---- hdl/liucd_defines.svh ----
// register map, field positions, reset values and counts of the channel diagnostics
`ifndef LIUCD_DEFINES_SVH
`define LIUCD_DEFINES_SVH

`define LIUCD_ADDR_CHAN_CTRL 8'h01
`define LIUCD_ADDR_STATUS 8'h02
`define LIUCD_ADDR_JA_CTRL 8'h07

`define LIUCD_CTRL_PTE 0
`define LIUCD_CTRL_INJ 1
`define LIUCD_CTRL_RLB 2
`define LIUCD_CTRL_LLB 3
`define LIUCD_CTRL_TAOS 4
`define LIUCD_CTRL_E3 5
`define LIUCD_CTRL_MASK 8'h3f

`define LIUCD_JA_B0 0
`define LIUCD_JA_TX 1
`define LIUCD_JA_B1 2
`define LIUCD_JA_RST 3
`define LIUCD_JA_MASK 8'h0f

`define LIUCD_STAT_SYNCLOST 0
`define LIUCD_STAT_LOCKED 1

`define LIUCD_RESET_VAL 8'h00
`define LIUCD_JA_DEPTH_SHORT 5'h10
`define LIUCD_JA_DEPTH_LONG 5'h00
`define LIUCD_LOOP_MAP_DEF 8'hb4
`define LIUCD_PRBS_SEED 23'h000001
`define LIUCD_LOCK_RUN 5'h1f
`define LIUCD_LOSS_ERRS 3'h4

`endif

// ---- hdl/liucd_pkg.sv ----
// types shared by the channel diagnostics modules
package liucd_pkg;

    typedef enum logic [1:0] {
        LIUCD_LOOP_NONE    = 2'b00,
        LIUCD_LOOP_ANALOG  = 2'b01,
        LIUCD_LOOP_DIGITAL = 2'b10,
        LIUCD_LOOP_REMOTE  = 2'b11
    } liucd_loop_e;

    typedef logic [1:0] liucd_rail_t;

endpackage : liucd_pkg

// ---- hdl/liucd_ja_mem.sv ----
// jitter attenuator buffer: 32 two-rail entries, flushable, registered read
`timescale 1ns/1ps
module liucd_ja_mem (
    input wire logic clk,
    input wire logic rstn,
    input wire logic flush,
    input wire logic we,
    input wire logic [4:0] waddr,
    input wire liucd_pkg::liucd_rail_t wdata,
    input wire logic [4:0] raddr,
    output liucd_pkg::liucd_rail_t rdata
);
    liucd_pkg::liucd_rail_t mem_r [0:31];

    genvar gi;
    generate
        for (gi = 0; gi < 32; gi = gi + 1) begin : g_entry
            always_ff @(posedge clk or negedge rstn) begin
                if (!rstn) begin
                    mem_r[gi] <= 2'h0;
                end else if (flush) begin
                    mem_r[gi] <= 2'h0;
                end else if (we && waddr == 5'(gi)) begin
                    mem_r[gi] <= wdata;
                end
            end
        end
    endgenerate

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 2'h0;
        end else begin
            rdata <= flush ? 2'h0 : mem_r[raddr];
        end
    end
endmodule : liucd_ja_mem

// ---- hdl/liucd_prbs_chk.sv ----
// receive pattern checker: locks, then free-runs so each bad bit gives one flag
`timescale 1ns/1ps
`include "liucd_defines.svh"
module liucd_prbs_chk (
    input wire logic clk,
    input wire logic rstn,
    input wire logic enable,
    input wire logic long_mode,
    input wire logic ev,
    input wire logic din,
    output logic locked,
    output logic err_hold
);
    logic [22:0] sh_r;
    logic [4:0] run_r;
    logic [2:0] errs_r;
    wire pred = long_mode ? (sh_r[22] ^ sh_r[17]) : (sh_r[14] ^ sh_r[13]);
    wire mism = din ^ pred;
    // unlocked, the register follows the line; locked, it follows its own prediction
    wire shin = locked ? pred : din;
    wire run_done = !mism && run_r == `LIUCD_LOCK_RUN - 5'h1;
    wire lose = locked && mism && errs_r == `LIUCD_LOSS_ERRS - 3'h1;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sh_r <= 23'h0;
            run_r <= 5'h0;
            errs_r <= 3'h0;
            locked <= 1'b0;
            err_hold <= 1'b0;
        end else if (!enable) begin
            run_r <= 5'h0;
            errs_r <= 3'h0;
            locked <= 1'b0;
            err_hold <= 1'b0;
        end else if (ev) begin
            sh_r <= {sh_r[21:0], shin};
            run_r <= mism ? 5'h0 : (run_done ? 5'h0 : run_r + 5'h1);
            errs_r <= run_done ? 3'h0 : (lose ? 3'h0 : errs_r + {2'h0, locked & mism});
            locked <= (locked & ~lose) | run_done;
            // flag stands one receive clock cycle, until the next event
            err_hold <= locked & mism & ~lose;
        end
    end
endmodule : liucd_prbs_chk

// ---- testbench/liucd_framer_model.sv ----
// terminal framer model: free-running transmit clock and dual-rail transmit data
`timescale 1ns/1ps
module liucd_framer_model (
    input wire logic want_p,
    input wire logic want_n,
    output logic term_clk,
    output logic term_p,
    output logic term_n
);
    initial begin
        term_clk = 1'b0;
        term_p = 1'b0;
        term_n = 1'b0;
    end
    // terminal transmit clock runs continuously, 160 ns period
    always #80 term_clk = ~term_clk;
    // launched on the falling edge so the rails are stable a half period around each rise
    always @(negedge term_clk) begin
        term_p <= want_p;
        term_n <= want_n;
    end
endmodule : liucd_framer_model

// ---- testbench/testbench.sv ----
// self-checking bench: registers, pattern test, loopbacks, all-ones, attenuator lag
`timescale 1ns/1ps
module testbench;
    logic clk = 1'b0, rstn = 1'b0, wstb = 1'b0, rstb = 1'b0, host = 1'b1;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, v, c;
    logic rlb = 1'b0, llb = 1'b0, aos = 1'b0, want_p = 1'b1, want_n = 1'b0;
    logic lclk = 1'b0, lrx_p = 1'b0, lrx_n = 1'b0, lrx_tog = 1'b0;
    logic tclk, tp, tn, rclk, rxp, vio, ltp, ltn, psl, vio_q, ltp_q, ltn_q;
    int n_errors = 0, n_checks = 0, n_lclk = 0, i, e;
    int n_vio, n_p, n_n, n_both, w, wmin, wmax;
    logic [23:0] rows [7];

    liucd_framer_model i_framer (.want_p(want_p), .want_n(want_n), .term_clk(tclk),
        .term_p(tp), .term_n(tn));
    liucd_top #(.LOOP_MAP(8'hb4)) i_dut (
        .CLK(clk), .RSTN(rstn), .ADDR(addr), .WDATA(wdata), .WR(wstb), .RD(rstb),
        .RDATA(rdata), .HOST_MODE(host), .REMOTE_LOOP_SELECT(rlb), .LOCAL_LOOP_SELECT(llb),
        .SEND_ALL_ONES(aos), .TERMINAL_TX_CLOCK(tclk), .TX_POSITIVE_DATA(tp),
        .TX_NEGATIVE_DATA(tn), .LINE_RX_CLOCK(lclk), .LINE_RX_POSITIVE(lrx_p),
        .LINE_RX_NEGATIVE(lrx_n), .RECEIVE_CLOCK_OUT(rclk), .RX_POSITIVE_DATA(rxp),
        .RX_LOW_RAIL_VIOLATION_OUT(vio), .LINE_TX_POSITIVE(ltp), .LINE_TX_NEGATIVE(ltn),
        .PATTERN_SYNC_LOST(psl));

    always #5 clk = ~clk;
    initial begin
        #3;
        forever #80 lclk = ~lclk;
    end
    always @(posedge lclk) n_lclk++;
    // the positive rail wiggles during analog loop so that ignoring it shows
    always @(negedge lclk) if (lrx_tog) lrx_p <= ~lrx_p;

    always @(posedge clk) begin
        vio_q <= vio;
        ltp_q <= ltp;
        ltn_q <= ltn;
        if (vio === 1'b1 && vio_q !== 1'b1) n_vio++;
        if (vio === 1'b1) w++;
        else if (w > 0) begin
            wmin = (w < wmin) ? w : wmin;
            wmax = (w > wmax) ? w : wmax;
            w = 0;
        end
        if (ltp === 1'b1 && ltp_q !== 1'b1) n_p++;
        if (ltn === 1'b1 && ltn_q !== 1'b1) n_n++;
        if (ltp === 1'b1 && ltn === 1'b1) n_both++;
    end

    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic chk_in(input string what, input int lo, input int hi, input int got);
        n_checks++;
        if (got < lo || got > hi) begin
            n_errors++;
            $display("BAD %s expected %0d..%0d seen %0d", what, lo, hi, got);
        end
    endtask : chk_in
    task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wstb <= 1'b1;
        @(posedge clk);
        wstb <= 1'b0;
    endtask : reg_wr
    task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rstb <= 1'b1;
        @(posedge clk);
        rstb <= 1'b0;
        #1 d = rdata;
    endtask : reg_rd
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc
    // settle for 100 cycles, then count line and flag events over n cycles
    task automatic soak(input int n);
        cyc(100);
        @(negedge clk);
        n_vio = 0;
        n_p = 0;
        n_n = 0;
        n_both = 0;
        w = 0;
        wmin = 999;
        wmax = 0;
        cyc(n);
    endtask : soak
    task automatic await_lock;
        int k;
        for (k = 0; k < 3000 && psl !== 1'b0; k++) @(posedge clk);
        if (k == 3000) begin
            n_errors++;
            $display("BAD lock wait expected lock seen none");
            wrap_up();
        end
    endtask : await_lock
    // remote loop: step the line rails, count line clocks until each output follows
    task automatic lag_case(input logic [7:0] ja, input logic tgt, input int rlo,
        input int rhi, input int tlo, input int thi);
        int s, lr, lt, k;
        reg_wr(8'h07, ja);
        cyc(700);
        @(negedge lclk);
        lrx_p <= tgt;
        lrx_n <= ~tgt;
        s = n_lclk;
        lr = -1;
        lt = -1;
        for (k = 0; k < 1500; k++) begin
            @(posedge clk);
            if (lr < 0 && rxp === tgt) lr = n_lclk - s;
            if (lt < 0 && ltp === tgt) lt = n_lclk - s;
        end
        chk_in("rx lag", rlo, rhi, lr);
        chk_in("tx lag", tlo, thi, lt);
    endtask : lag_case
    task automatic wrap_up;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : wrap_up

    initial begin
        rows = '{24'h07ff0f, 24'h070101, 24'h01ff3f, 24'h010000, 24'h02ff00, 24'h05ff00,
            24'h005a00};
        repeat (12) @(posedge clk);
        chk("rdata in reset", 8'h00, rdata);
        chk("outputs in reset", 8'h00, {2'h0, rclk, rxp, vio, ltp, ltn, psl});
        rstn <= 1'b1;
        for (i = 0; i < 3; i++) begin
            reg_rd((i == 0) ? 8'h01 : ((i == 1) ? 8'h02 : 8'h07), v);
            chk("reset value", 8'h00, v);
        end
        foreach (rows[k]) begin
            reg_wr(rows[k][23:16], rows[k][15:8]);
            reg_rd(rows[k][23:16], v);
            chk("readback", rows[k][7:0], v);
        end
        // pin control: digital loop and all-ones from pins, pattern bit has no effect
        @(posedge clk);
        host <= 1'b0;
        rlb <= 1'b1;
        llb <= 1'b1;
        aos <= 1'b1;
        reg_wr(8'h01, 8'h01);
        soak(640);
        chk("pin mode sync lost", 8'h00, {7'h0, psl});
        chk_in("pin ones positive", 15, 25, n_p);
        chk_in("pin ones negative", 15, 25, n_n);
        chk_in("both rails", 0, 0, n_both);
        chk("pin loop data", 8'h01, {7'h0, rxp});
        @(posedge tclk);
        #60 chk("rx clock high", 8'h01, {7'h0, rclk});
        @(negedge tclk);
        #60 chk("rx clock low", 8'h00, {7'h0, rclk});
        want_p = 1'b0;
        cyc(640);
        chk("pin loop data low", 8'h00, {7'h0, rxp});
        want_p = 1'b1;
        host <= 1'b1;
        rlb <= 1'b0;
        llb <= 1'b0;
        aos <= 1'b0;
        reg_wr(8'h01, 8'h00);
        // pattern test in analog loop, both sequence lengths
        lrx_tog = 1'b1;
        for (e = 0; e < 2; e++) begin
            c = (e == 1) ? 8'h29 : 8'h09;
            reg_wr(8'h07, (e == 1) ? 8'h00 : 8'h01);
            reg_wr(8'h01, c);
            cyc(20);
            chk("sync lost early", 8'h01, {7'h0, psl});
            chk("flag early", 8'h01, {7'h0, vio});
            await_lock();
            reg_rd(8'h02, v);
            chk("status locked", 8'h02, v);
            chk("flag locked", 8'h00, {7'h0, vio});
            soak(0);
            reg_wr(8'h01, c | 8'h02);
            cyc(400);
            // inject bit still one: no second error
            reg_wr(8'h01, c | 8'h02);
            cyc(400);
            chk_in("error pulses", 1, 1, n_vio);
            reg_wr(8'h01, c);
            reg_wr(8'h01, c | 8'h02);
            cyc(400);
            chk_in("error pulses", 2, 2, n_vio);
            chk_in("pulse width min", 14, 18, wmin);
            chk_in("pulse width max", 14, 18, wmax);
            chk_in("negative rail marks", 0, 0, n_n);
            chk("still locked", 8'h00, {7'h0, psl});
            reg_wr(8'h01, 8'h00);
        end
        reg_wr(8'h07, 8'h01);
        lrx_tog = 1'b0;
        @(negedge lclk);
        lrx_p <= 1'b0;
        lrx_n <= 1'b1;
        // all-ones in digital, analog and remote loop
        reg_wr(8'h01, 8'h1c);
        soak(640);
        chk_in("digital ones positive", 15, 25, n_p);
        chk_in("digital ones negative", 15, 25, n_n);
        chk("digital loop data", 8'h01, {7'h0, rxp});
        reg_wr(8'h01, 8'h18);
        soak(640);
        chk_in("analog ones negative", 0, 0, n_n);
        chk("analog line data", 8'h01, {7'h0, ltp});
        reg_wr(8'h01, 8'h14);
        soak(640);
        chk_in("remote positive marks", 0, 0, n_p);
        chk("remote line data", 8'h01, {6'h0, ltp, ltn});
        chk("remote rx data", 8'h00, {7'h0, rxp});
        // attenuator placement, depth and flush in remote loop
        reg_wr(8'h01, 8'h04);
        lag_case(8'h02, 1'b1, 0, 2, 15, 18);
        lag_case(8'h00, 1'b0, 15, 18, 15, 18);
        lag_case(8'h06, 1'b1, 0, 2, 31, 34);
        reg_wr(8'h07, 8'h0e);
        reg_rd(8'h07, v);
        chk("flush bit", 8'h0e, v);
        cyc(100);
        chk("flushed line", 8'h00, {6'h0, ltp, ltn});
        lag_case(8'h06, 1'b0, 0, 2, 31, 34);
        wrap_up();
    end
endmodule : testbench
